// >>> core/otp_pkg.sv
// constants, encodings and state types of the secure otp logic
// assumes one 100 mhz clock and a 16-bit word bus
package otp_pkg;
    // =====================================================
    // commands
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_OTP_PROG = 8'hc0;

    // =====================================================
    // identifier space offsets
    localparam int ADDR_W = 16;
    localparam logic [15:0] OFS_LOCK_FIRST = 16'h0080;
    localparam logic [15:0] OFS_GRP0_LO = 16'h0081;
    localparam logic [15:0] OFS_GRP0_HI = 16'h0085;
    localparam logic [15:0] OFS_LOCK_UPPER = 16'h0089;
    localparam logic [15:0] OFS_GRP_UPPER = 16'h008a;
    localparam logic [15:0] OFS_OTP_END = 16'h0109;
    localparam int OTP_WORDS = 136;
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_UPPER_BASE = 8'h08;
    localparam int GRP_SHIFT = 3;
    localparam int UPPER_GROUPS = 16;

    // =====================================================
    // word values
    localparam logic [15:0] WORD_BLANK = 16'hffff;
    localparam logic [15:0] LOCK_FIRST_FACTORY = 16'hfffe;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam int LOCK_UID_BIT = 0;
    localparam int LOCK_USER_BIT = 1;

    // =====================================================
    // flag word
    localparam logic [7:0] FLAG_RESET = 8'h80;
    localparam int FLAG_READY_BIT = 7;
    localparam int FLAG_PROG_ERR_BIT = 4;
    localparam int FLAG_LOCK_VIOL_BIT = 1;

    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 150;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // =====================================================
    // selectable otp areas, block numbers
    localparam int BLK_W = 9;
    localparam int AREAS = 4;
    localparam logic [8:0] TOP_PARAM_LO = 9'd255;
    localparam logic [8:0] TOP_PARAM_HI = 9'd258;
    localparam logic [8:0] TOP_MAIN_FIRST = 9'd254;
    localparam logic [8:0] BOT_PARAM_LO = 9'd0;
    localparam logic [8:0] BOT_PARAM_HI = 9'd3;
    localparam logic [8:0] BOT_MAIN_FIRST = 9'd4;

    typedef enum logic [1:0] {
        RM_ASYNC_SINGLE = 2'b00,
        RM_ASYNC_PAGE = 2'b01,
        RM_SYNC_BURST = 2'b10
    } otp_rd_mode_t;

    typedef enum logic [1:0] {
        VIEW_ARRAY = 2'b00,
        VIEW_STATUS = 2'b01,
        VIEW_ID = 2'b11
    } otp_view_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_FETCH = 3'b011,
        ST_WRITE = 3'b010,
        ST_BUSY = 3'b110
    } otp_state_t;
endpackage

// >>> core/otp_mem.sv
// nonvolatile word store of the otp groups, registered read data
// assumes single-cycle writes and content kept across reset
module otp_mem #(
    parameter int DEPTH = 136,
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    // blank cells read as all ones
    logic [DW-1:0] cells [DEPTH] = '{default: '1};

    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= cells[raddr];
    end
endmodule

// >>> core/otp_ctrl.sv
// secure otp groups, their lock words, flag word and non-array reads
// assumes host writes and reads synchronous to sys_clk, one per pulse
//
// Contract
// - four selectable array areas can be made otp, refusing program and erase; here only flagged on blk_otp_protected
// - areas are param blocks then three adjacent main blocks, top or bottom
// - seventeen otp groups, each lockable on its own
// - group 0 low half holds factory number, everything else but first lock word bit 0 starts blank
// - programmed bits never erase; unlocked groups accept more bits
// - one lock bit per upper group and per group 0 half, lock bits are one-time programmable
// - read-identifier command then read at group offset, 16 bits each
// - otp-program command at group address then data there, 16 bits
// - otp-program outside otp space sets program error flag
// - program to locked group sets program error and lock violation
// - lock words programmed at 0x80 and 0x89
// - first lock word bit 0 factory set, bit 1 locks group 0 user half
// - each upper lock word bit locks one upper group
// - non-array reads are single-word accesses
// - page mode non-array reads: only first word defined
// - burst non-array reads repeat the word for burst length
// - sequencer only sets error flags; clear command or reset clears them
// - identifier data returned until a read-array, read-status or otp-program command
module otp_ctrl
    import otp_pkg::*;
#(
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // arbitrary value
    parameter logic [15:0] ID_FILL = 16'h0000,
    parameter int BURST_W = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [otp_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] array_rdata,
    input wire otp_pkg::otp_rd_mode_t rd_mode,
    input wire logic [1:0] rd_page_idx,
    input wire logic [BURST_W-1:0] burst_len,
    input wire logic param_top_strap,
    input wire logic area_set_we,
    input wire logic [otp_pkg::AREAS-1:0] area_set_mask,
    input wire logic [otp_pkg::BLK_W-1:0] blk_query,
    output logic [15:0] rdata,
    output logic rdata_valid,
    output logic rdata_defined,
    output logic [7:0] flag_word,
    output logic blk_otp_protected
);
    import otp_pkg::*;

    // =====================================================
    // nonvolatile state
    logic [15:0] lock_first = LOCK_FIRST_FACTORY;
    logic [15:0] lock_upper = WORD_BLANK;
    logic [AREAS-1:0] area_otp = '0;

    // =====================================================
    // volatile state
    otp_state_t state;
    otp_view_t view;
    logic [15:0] prog_addr;
    logic [15:0] prog_data;
    logic [IDX_W-1:0] prog_idx;
    logic [CNT_W-1:0] busy_cnt;
    logic prog_err;
    logic lock_viol;
    logic param_top;
    logic strap_done;

    logic mem_we;
    logic [15:0] mem_wdata;
    logic [IDX_W-1:0] mem_raddr;
    logic [15:0] mem_rdata;

    // =====================================================
    // address classification
    function automatic logic in_otp(input logic [15:0] a);
        return a >= OFS_LOCK_FIRST && a <= OFS_OTP_END;
    endfunction

    function automatic logic [IDX_W-1:0] word_idx(input logic [15:0] a);
        logic [15:0] d;
        d = WORD_ZERO;
        if (a < OFS_LOCK_UPPER) begin
            d = a - OFS_GRP0_LO;
        end else begin
            d = a - OFS_GRP_UPPER + {8'h00, IDX_UPPER_BASE};
        end
        return d[IDX_W-1:0];
    endfunction

    // lock bit zero means locked
    function automatic logic grp_locked(input logic [15:0] a);
        logic [15:0] d;
        d = a - OFS_GRP_UPPER;
        if (a < OFS_GRP0_HI) begin
            return !lock_first[LOCK_UID_BIT];
        end else if (a < OFS_LOCK_UPPER) begin
            return !lock_first[LOCK_USER_BIT];
        end
        return !lock_upper[d[GRP_SHIFT+3:GRP_SHIFT]];
    endfunction

    logic [7:0] cmd;
    logic cmd_ok;
    assign cmd = bus_wdata[7:0];
    assign cmd_ok = bus_we && (state == ST_IDLE);

    // =====================================================
    // write sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            prog_addr <= WORD_ZERO;
            prog_data <= WORD_ZERO;
            prog_idx <= '0;
            busy_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_ok && cmd == CMD_OTP_PROG) begin
                        state <= ST_SETUP;
                        prog_addr <= bus_addr;
                    end
                end
                ST_SETUP: begin
                    if (bus_we) begin
                        prog_data <= bus_wdata;
                        prog_idx <= word_idx(prog_addr);
                        if (!in_otp(prog_addr)) begin
                            state <= ST_IDLE;
                        end else if (prog_addr == OFS_LOCK_FIRST ||
                                     prog_addr == OFS_LOCK_UPPER) begin
                            state <= ST_BUSY;
                            busy_cnt <= CNT_W'(PROG_CYCLES);
                        end else if (grp_locked(prog_addr)) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    state <= ST_WRITE;
                end
                ST_WRITE: begin
                    state <= ST_BUSY;
                    busy_cnt <= CNT_W'(PROG_CYCLES);
                end
                ST_BUSY: begin
                    if (busy_cnt <= CNT_W'(1)) begin
                        state <= ST_IDLE;
                    end else begin
                        busy_cnt <= busy_cnt - CNT_W'(1);
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // only ones can fall to zero; old bits stay programmed
    assign mem_we = (state == ST_WRITE);
    assign mem_wdata = mem_rdata & prog_data;
    assign mem_raddr = (state == ST_FETCH) ? prog_idx : word_idx(bus_addr);

    // =====================================================
    // lock words, never reset
    always_ff @(posedge sys_clk) begin
        if (state == ST_SETUP && bus_we && prog_addr == OFS_LOCK_FIRST) begin
            lock_first <= lock_first & bus_wdata;
        end
        if (state == ST_SETUP && bus_we && prog_addr == OFS_LOCK_UPPER) begin
            lock_upper <= lock_upper & bus_wdata;
        end
    end

    // =====================================================
    // error flags, set wins over clear
    logic set_perr;
    logic set_viol;
    logic clr_flags;
    assign set_perr = state == ST_SETUP && bus_we &&
        (!in_otp(prog_addr) || (prog_addr != OFS_LOCK_FIRST &&
         prog_addr != OFS_LOCK_UPPER && grp_locked(prog_addr)));
    assign set_viol = state == ST_SETUP && bus_we && in_otp(prog_addr) &&
        prog_addr != OFS_LOCK_FIRST && prog_addr != OFS_LOCK_UPPER &&
        grp_locked(prog_addr);
    assign clr_flags = cmd_ok && cmd == CMD_CLEAR_STATUS;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prog_err <= 1'b0;
        end else if (set_perr) begin
            prog_err <= 1'b1;
        end else if (clr_flags) begin
            prog_err <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lock_viol <= 1'b0;
        end else if (set_viol) begin
            lock_viol <= 1'b1;
        end else if (clr_flags) begin
            lock_viol <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flag_word <= FLAG_RESET;
        end else begin
            flag_word <= '0;
            flag_word[FLAG_READY_BIT] <= !(state == ST_FETCH ||
                state == ST_WRITE || state == ST_BUSY);
            flag_word[FLAG_PROG_ERR_BIT] <= prog_err;
            flag_word[FLAG_LOCK_VIOL_BIT] <= lock_viol;
        end
    end

    // =====================================================
    // read view selection
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            view <= VIEW_ARRAY;
        end else if (cmd_ok) begin
            case (cmd)
                CMD_READ_ARRAY: view <= VIEW_ARRAY;
                CMD_READ_ID: view <= VIEW_ID;
                CMD_READ_STATUS: view <= VIEW_STATUS;
                CMD_OTP_PROG: view <= VIEW_STATUS;
                default: view <= view;
            endcase
        end
    end

    // =====================================================
    // read pipeline
    logic rd_pend;
    logic rd_from_mem;
    logic rd_nonarray;
    logic [15:0] rd_imm;
    logic [BURST_W-1:0] beats_left;
    logic [15:0] uid_word;
    logic [1:0] uid_sel;
    logic [15:0] uid_off;

    assign uid_off = bus_addr - OFS_GRP0_LO;
    assign uid_sel = uid_off[1:0];
    assign uid_word = UNIQUE_ID[{uid_sel, 4'h0} +: 16];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_pend <= 1'b0;
            rd_from_mem <= 1'b0;
            rd_nonarray <= 1'b0;
            rd_imm <= WORD_ZERO;
        end else begin
            rd_pend <= bus_re;
            rd_from_mem <= 1'b0;
            rd_nonarray <= (view != VIEW_ARRAY);
            rd_imm <= array_rdata;
            if (bus_re && view == VIEW_STATUS) begin
                rd_imm <= {8'h00, flag_word};
            end else if (bus_re && view == VIEW_ID) begin
                if (bus_addr == OFS_LOCK_FIRST) begin
                    rd_imm <= lock_first;
                end else if (bus_addr == OFS_LOCK_UPPER) begin
                    rd_imm <= lock_upper;
                end else if (bus_addr >= OFS_GRP0_LO && bus_addr < OFS_GRP0_HI) begin
                    rd_imm <= uid_word;
                end else if (in_otp(bus_addr)) begin
                    rd_from_mem <= 1'b1;
                end else begin
                    rd_imm <= ID_FILL;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata <= WORD_ZERO;
            rdata_valid <= 1'b0;
            rdata_defined <= 1'b0;
            beats_left <= '0;
        end else if (rd_pend) begin
            rdata <= rd_from_mem ? mem_rdata : rd_imm;
            rdata_valid <= 1'b1;
            // single word unless burst on non-array
            rdata_defined <= !(rd_nonarray && rd_mode == RM_ASYNC_PAGE &&
                rd_page_idx != 2'b00);
            if (rd_nonarray && rd_mode == RM_SYNC_BURST && burst_len > BURST_W'(1)) begin
                beats_left <= burst_len - BURST_W'(1);
            end else begin
                beats_left <= '0;
            end
        end else if (beats_left != '0) begin
            rdata_valid <= 1'b1;
            beats_left <= beats_left - BURST_W'(1);
        end else begin
            rdata_valid <= 1'b0;
        end
    end

    // =====================================================
    // selectable otp areas
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            strap_done <= 1'b0;
            param_top <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            param_top <= param_top_strap;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (area_set_we) begin
            area_otp <= area_otp | area_set_mask;
        end
    end

    logic [AREAS-1:0] area_hit;
    // main areas step away from the parameter blocks
    assign area_hit[0] = param_top ?
        (blk_query >= TOP_PARAM_LO && blk_query <= TOP_PARAM_HI) :
        (blk_query >= BOT_PARAM_LO && blk_query <= BOT_PARAM_HI);
    genvar gi;
    generate
        for (gi = 1; gi < AREAS; gi++) begin : g_main_area
            assign area_hit[gi] = param_top ?
                (blk_query == TOP_MAIN_FIRST - BLK_W'(gi - 1)) :
                (blk_query == BOT_MAIN_FIRST + BLK_W'(gi - 1));
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            blk_otp_protected <= 1'b0;
        end else begin
            blk_otp_protected <= |(area_hit & area_otp);
        end
    end

    // =====================================================
    // group store
    otp_mem #(
        .DEPTH(OTP_WORDS),
        .AW(IDX_W),
        .DW(16)
    ) u_store (
        .clk(sys_clk),
        .we(mem_we),
        .waddr(prog_idx),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );
endmodule

// >>> sim/otp_ctrl_checker.sv
// concurrent checks on the ports of the secure otp controller
// assumes otp_pkg codes, one sys_clk domain, bound into otp_ctrl
module otp_ctrl_checker
    import otp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [15:0] bus_wdata,
    input wire otp_pkg::otp_rd_mode_t rd_mode,
    input wire logic [15:0] rdata,
    input wire logic rdata_valid,
    input wire logic [7:0] flag_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clr;
    logic in_setup;
    // data write after an otp-program command is no command
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            in_setup <= 1'b0;
        end else if (bus_we) begin
            in_setup <= !in_setup && flag_word[FLAG_READY_BIT] &&
                bus_wdata[7:0] == CMD_OTP_PROG;
        end
    end
    assign clr = bus_we && !in_setup && bus_wdata[7:0] == CMD_CLEAR_STATUS &&
        flag_word[FLAG_READY_BIT];
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // =====================================================
    // assertions
    a_flag_reset_val: assert property (disable iff (1'b0)
        !nrst |=> flag_word == FLAG_RESET && !rdata_valid)
        else $error("flag word or valid wrong after reset");
    a_read_answer_time: assert property (bus_re |-> ##2 rdata_valid)
        else $error("read not answered two cycles later");
    a_valid_has_cause: assert property ($rose(rdata_valid) |-> $past(bus_re, 2))
        else $error("read data valid without a read");
    a_clear_drops_flags: assert property (clr |-> ##[1:2]
        (!flag_word[FLAG_PROG_ERR_BIT] && !flag_word[FLAG_LOCK_VIOL_BIT]))
        else $error("clear command left error flags set");
    a_flags_held_sticky: assert property (($fell(flag_word[4]) || $fell(flag_word[1]))
        |-> $past(clr, 1) || $past(clr, 2) || $past(clr, 3))
        else $error("error flag dropped without clear");
    a_busy_min_span: assert property ($fell(flag_word[7]) |-> (!flag_word[7])[*8])
        else $error("ready returned too early");
    a_busy_max_span: assert property ($fell(flag_word[7]) |-> ##[1:40] flag_word[7])
        else $error("ready never returned");
    a_busy_from_write: assert property ($fell(flag_word[7]) |->
        $past(bus_we, 2) || $past(bus_we, 3) || $past(bus_we, 4) || $past(bus_we, 5))
        else $error("busy without a data write");
    a_burst_same_word: assert property (rdata_valid && $past(rdata_valid)
        && rd_mode == RM_SYNC_BURST |-> $stable(rdata))
        else $error("burst word changed");
    c_burst: cover property (rd_mode == RM_SYNC_BURST && rdata_valid ##1 rdata_valid);
    c_prog: cover property ($fell(flag_word[7]));
    c_lock_err: cover property ($rose(flag_word[1]));
endmodule

bind otp_ctrl otp_ctrl_checker u_otp_ctrl_checker (.sys_clk(sys_clk), .nrst(nrst),
    .bus_we(bus_we), .bus_re(bus_re), .bus_wdata(bus_wdata), .rd_mode(rd_mode),
    .rdata(rdata), .rdata_valid(rdata_valid), .flag_word(flag_word));

// >>> sim/otp_host.sv
// host bus model driving commands, data and reads into the otp controller
// assumes strobes sampled on rising sys_clk, driven at falling edges
module otp_host
    import otp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] flag_word,
    input wire logic rdata_valid,
    input wire logic rdata_defined,
    input wire logic [15:0] rdata,
    output logic bus_we,
    output logic bus_re,
    output logic [15:0] bus_addr,
    output logic [15:0] bus_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_we = 0;
        bus_re = 0;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
    end
    // =====================================================
    // bus cycles; released lines show inverted junk
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = v;
        bus_we = 1;
        @(negedge sys_clk);
        bus_we = 0;
        bus_addr = ~a;
        bus_wdata = ~v;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output int n,
        output logic df);
        int i;
        @(negedge sys_clk);
        bus_addr = a;
        bus_re = 1;
        @(negedge sys_clk);
        bus_re = 0;
        bus_addr = ~a;
        n = 0;
        for (i = 0; i < 8 && rdata_valid !== 1'b1; i++) @(negedge sys_clk);
        d = rdata;
        df = rdata_defined;
        while (rdata_valid === 1'b1 && rdata === d && n < 64) begin
            n++;
            @(negedge sys_clk);
        end
    endtask
    task automatic prog(input logic [15:0] a, input logic [15:0] v);
        int i;
        wr(a, {8'h00, CMD_OTP_PROG});
        wr(a, v);
        repeat (3) @(negedge sys_clk);
        for (i = 0; i < 40 && flag_word[7] !== 1'b1; i++) @(negedge sys_clk);
    endtask
endmodule

// >>> sim/tb_otp_ctrl.sv
// self-checking bench for the secure otp controller
// assumes otp_host as bus partner and the bound port checker
module tb_otp_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import otp_pkg::*;
    localparam logic [63:0] UID = 64'h1122334455667788; // arbitrary value
    logic sys_clk, nrst, strap, area_we, bus_we, bus_re, rdv, rdf, prot, df;
    logic [15:0] bus_addr, bus_wdata, rdata, arr, d;
    logic [7:0] flag_word;
    otp_rd_mode_t rd_mode;
    logic [1:0] page;
    logic [5:0] blen;
    logic [3:0] amask;
    logic [8:0] blk;
    int fails, cmp_count, n;
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    otp_ctrl #(.UNIQUE_ID(UID)) u_otp_ctrl (.sys_clk(sys_clk), .nrst(nrst), .bus_we(bus_we),
        .bus_re(bus_re), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .array_rdata(arr),
        .rd_mode(rd_mode), .rd_page_idx(page), .burst_len(blen), .param_top_strap(strap),
        .area_set_we(area_we), .area_set_mask(amask), .blk_query(blk), .rdata(rdata),
        .rdata_valid(rdv), .rdata_defined(rdf), .flag_word(flag_word),
        .blk_otp_protected(prot));
    otp_host u_otp_host (.sys_clk(sys_clk), .flag_word(flag_word), .rdata_valid(rdv),
        .rdata_defined(rdf), .rdata(rdata), .bus_we(bus_we), .bus_re(bus_re),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata));
    // =====================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rid(input logic [15:0] a, input logic [15:0] e);
        u_otp_host.rd(a, d, n, df);
        chk("id word", d, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        u_otp_host.wr(16'h1234, {8'h00, c});
    endtask
    task automatic qb(input logic [8:0] b, input logic e);
        @(negedge sys_clk);
        blk = b;
        @(negedge sys_clk);
        chk("area protect", prot, e);
    endtask
    task automatic rst(input logic top);
        @(negedge sys_clk);
        nrst = 0;
        strap = top;
        repeat (2) @(negedge sys_clk);
        nrst = 1;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
    // =====================================================
    // tests
    initial begin
        {nrst, strap, area_we, amask, blk, page, fails, cmp_count} = '0;
        rd_mode = RM_ASYNC_SINGLE;
        blen = 6'd4;
        arr = 16'hc3c3;
        rst(1'b0);
        chk("flag reset", flag_word, FLAG_RESET);
        cmd(CMD_READ_ID);
        rid(OFS_LOCK_FIRST, LOCK_FIRST_FACTORY);
        for (int i = 0; i < 4; i++) rid(OFS_GRP0_LO + 16'(i), UID[16*i +: 16]);
        rid(OFS_GRP0_HI, WORD_BLANK);
        rid(OFS_OTP_END, WORD_BLANK);
        $display("test id_space done");
        u_otp_host.prog(OFS_GRP_UPPER, 16'h5a5a);
        chk("ready", flag_word, FLAG_RESET);
        u_otp_host.prog(OFS_GRP_UPPER, 16'hff0f);
        cmd(CMD_READ_ID);
        rid(OFS_GRP_UPPER, 16'h5a0a);
        $display("test program done");
        u_otp_host.prog(16'h0010, 16'h0000);
        chk("outside space", flag_word, 8'h90);
        cmd(CMD_READ_STATUS);
        u_otp_host.rd(16'h0010, d, n, df);
        chk("status read", d, 16'h0090);
        cmd(CMD_READ_ARRAY);
        chk("flags held", flag_word, 8'h90);
        u_otp_host.rd(16'h0010, d, n, df);
        chk("array read", d, arr);
        cmd(CMD_CLEAR_STATUS);
        repeat (2) @(negedge sys_clk);
        chk("flags cleared", flag_word, FLAG_RESET);
        $display("test errors done");
        u_otp_host.prog(OFS_LOCK_UPPER, 16'hfffe);
        u_otp_host.prog(OFS_GRP_UPPER, 16'h0000);
        chk("locked group", flag_word, 8'h92);
        cmd(CMD_CLEAR_STATUS);
        u_otp_host.prog(OFS_GRP_UPPER + 16'd8, 16'h1234);
        chk("open group", flag_word, FLAG_RESET);
        u_otp_host.prog(OFS_LOCK_FIRST, 16'hfffd);
        u_otp_host.prog(OFS_GRP0_HI, 16'h0000);
        chk("user half locked", flag_word, 8'h92);
        u_otp_host.prog(OFS_GRP0_LO, 16'h0000);
        cmd(CMD_READ_ID);
        rid(OFS_GRP0_LO, UID[15:0]);
        rid(OFS_GRP0_HI, WORD_BLANK);
        rid(OFS_GRP_UPPER, 16'h5a0a);
        rid(OFS_GRP_UPPER + 16'd8, 16'h1234);
        rid(OFS_LOCK_UPPER, 16'hfffe);
        rid(OFS_LOCK_FIRST, 16'hfffc);
        $display("test locks done");
        rd_mode = RM_ASYNC_PAGE;
        page = 2'd1;
        u_otp_host.rd(OFS_LOCK_UPPER, d, n, df);
        chk("page later word", df, 1'b0);
        page = 2'd0;
        u_otp_host.rd(OFS_LOCK_UPPER, d, n, df);
        chk("page first word", {df, d}, {1'b1, 16'hfffe});
        rd_mode = RM_SYNC_BURST;
        u_otp_host.rd(OFS_LOCK_UPPER, d, n, df);
        chk("burst repeats", n, 4);
        rd_mode = RM_ASYNC_SINGLE;
        u_otp_host.rd(OFS_LOCK_UPPER, d, n, df);
        chk("single word", n, 1);
        $display("test read_modes done");
        @(negedge sys_clk);
        amask = 4'b0011;
        area_we = 1;
        @(negedge sys_clk);
        area_we = 0;
        qb(9'd3, 1'b1);
        qb(9'd4, 1'b1);
        qb(9'd5, 1'b0);
        qb(9'd7, 1'b0);
        rst(1'b1);
        qb(9'd258, 1'b1);
        qb(9'd255, 1'b1);
        qb(9'd254, 1'b1);
        qb(9'd253, 1'b0);
        chk("flag after reset", flag_word, FLAG_RESET);
        cmd(CMD_READ_ID);
        rid(OFS_LOCK_UPPER, 16'hfffe);
        $display("test areas done");
        finish_test();
    end
endmodule
